// File: src/mviu_defines.svh
// Register offsets, bit positions, reset values and vectors of the vectored interrupt unit.
`ifndef MVIU_DEFINES_SVH
`define MVIU_DEFINES_SVH

// Data-memory addresses of the two control registers.
`define MVIU_ADDR_PRIMARY      8'h0B
`define MVIU_ADDR_SECONDARY    8'h1E

// Field positions in the primary control register.
`define MVIU_P_GLOBAL_EN       0
`define MVIU_P_EXT0_EN         1
`define MVIU_P_EXT1_EN         2
`define MVIU_P_TIMER_EN        3
`define MVIU_P_EXT0_REQ        4
`define MVIU_P_EXT1_REQ        5
`define MVIU_P_TIMER_REQ       6

// Field positions in the secondary control register.
`define MVIU_S_CONV_EN         0
`define MVIU_S_CONV_REQ        4

// Reset values: every enable and every request flag clear.
`define MVIU_RST_ENABLES       4'h0
`define MVIU_RST_REQUESTS      4'h0
`define MVIU_RST_BYTE          8'h00

// Fixed call vectors, highest priority first.
`define MVIU_VEC_EXT0          8'h04
`define MVIU_VEC_EXT1          8'h08
`define MVIU_VEC_TIMER         8'h0C
`define MVIU_VEC_CONV          8'h10

// Source indices inside the request and enable vectors.
`define MVIU_SRC_EXT0          0
`define MVIU_SRC_EXT1          1
`define MVIU_SRC_TIMER         2
`define MVIU_SRC_CONV          3

`endif

// File: src/mviu_pkg.sv
// Types shared by the vectored interrupt unit modules.
package mviu_pkg;

  // Register state of the interrupt unit top.
  typedef struct packed {
    logic [3:0] request;
    logic [3:0] enable;
    logic       global_irq_enable;
    logic [3:0] wake_block;
    logic       power_down_seen;
    logic       ack;
    logic [7:0] vector;
    logic       wake;
    logic [7:0] rd_data;
  } mviu_state_type;

  // Register state of one edge detector.
  typedef struct packed {
    logic primed;
    logic prev;
  } mviu_edge_state_type;

endpackage : mviu_pkg

// File: src/mviu_edge_if.sv
// Carrier between the unit top and one external pin edge detector.
`timescale 1ns/1ps
interface mviu_edge_if;
  logic pin;
  logic pin_enable;
  logic rising;
  logic hit;

  modport detector (input pin, input pin_enable, input rising, output hit);
  modport owner    (output pin, output pin_enable, output rising, input hit);
endinterface : mviu_edge_if

// File: src/mviu_edge_detect.sv
// Edge detector for one external interrupt pin.
`timescale 1ns/1ps
module mviu_edge_detect (
  // Clock, reset and enable
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  // Pin and configuration
  mviu_edge_if.detector    edge_bus
);
  import mviu_pkg::*;

  mviu_edge_state_type st_r;
  mviu_edge_state_type st_nxt;

  // The first enabled cycle only loads the pin, so a pin already at its active level
  // after reset is not mistaken for an edge.
  always_comb begin
    st_nxt = st_r;
    if (edge_bus.pin_enable) begin
      st_nxt.primed = 1'b1;
      st_nxt.prev   = edge_bus.pin;
    end else begin
      st_nxt.primed = 1'b0;
    end
  end

  // Falling or rising edge chosen by the configuration option. [RQ5]
  assign edge_bus.hit = edge_bus.pin_enable && st_r.primed &&
                        (edge_bus.rising ? (edge_bus.pin && !st_r.prev) : (!edge_bus.pin && st_r.prev));

  // State register, frozen while the clock enable is low.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else if (clk_en) begin
      st_r <= st_nxt;
    end
  end

  AST_EDGE_NEEDS_ENABLE: assert property (@(posedge clock) disable iff (!rst_n)
    edge_bus.hit |-> edge_bus.pin_enable && (edge_bus.pin != st_r.prev)) // [RQ5]
    else $error("Edge hit without an enabled pin transition.");

endmodule : mviu_edge_detect

// File: src/mviu_unit.sv
// Vectored interrupt unit: control registers, request latching, priority and acknowledge.
`timescale 1ns/1ps
`include "mviu_defines.svh"

// Functional notes
// (RQ1) Four sources; enables and flags live at data addresses 0BH and 1EH.
// (RQ2) Servicing clears the global enable; later requests only set their flags.
// (RQ3) No acknowledge while the stack is full; wait until it drains.
// (RQ4) Acknowledge pushes only the program counter, then branches to the vector.
// (RQ5) External pins set flag bit 4 or 5 on the configured edge.
// (RQ6) External acknowledge calls 04H or 08H, clearing its flag and global enable.
// (RQ7) Timer overflow sets bit 6; acknowledge calls 0CH and clears flag and global enable.
// (RQ8) Either converter timer overflow sets its flag; acknowledge calls 10H.
// (RQ9) Return-from-interrupt sets the global enable; plain return leaves it.
// (RQ10) Requests arriving between phase-two pulses are serviced at the next pulse.
// (RQ11) Fixed priority: pin 0, pin 1, timer, converter; global enable masks all.
// (RQ12) Primary register: enables in bits 0 to 3, bit 7 reads zero.
// (RQ13) Secondary register: enable bit 0, flag bit 4, other bits read zero.
// (RQ14) A flag stays set until serviced or cleared by software.
// (RQ15) Software re-enables inside the handler for nesting and keeps stack room.
// (RQ16) Every source can wake the device from power-down.
// (RQ17) A source whose flag was set at power-down entry cannot wake it.
// (RQ18) Eligible only when flag, source enable and global enable are all one.
module mviu_unit (
  // Clock, reset and enable
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  // Data-memory access from the core
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rd_data,
  // Interrupt sources
  input  wire logic        ext_irq_pin_a,
  input  wire logic        ext_irq_pin_b,
  input  wire logic        timer_overflow,
  input  wire logic        conv_timer_a_overflow,
  input  wire logic        conv_timer_b_overflow,
  // Configuration options of the external pins
  input  wire logic        cfg_pin_a_enable,
  input  wire logic        cfg_pin_a_rising,
  input  wire logic        cfg_pin_b_enable,
  input  wire logic        cfg_pin_b_rising,
  // Core sequencer
  input  wire logic        phase_two_pulse,
  input  wire logic        stack_full,
  input  wire logic        return_from_irq_op,
  input  wire logic        plain_return_op,
  input  wire logic        power_down,
  // Acknowledge to the core
  output logic             irq_ack,
  output logic      [7:0]  irq_vector,
  output logic             wake_up
);
  import mviu_pkg::*;

  mviu_state_type st_r;
  mviu_state_type st_nxt;
  logic [3:0]     source_set;
  logic [3:0]     eligible;
  logic [3:0]     winner;
  logic           take_ack;
  logic [7:0]     win_vector;
  logic           wr_primary;
  logic           wr_secondary;

  mviu_edge_if pin_a_bus ();
  mviu_edge_if pin_b_bus ();

  // Pin configuration handed to the two edge detectors.
  assign pin_a_bus.pin        = ext_irq_pin_a;
  assign pin_a_bus.pin_enable = cfg_pin_a_enable;
  assign pin_a_bus.rising     = cfg_pin_a_rising;
  assign pin_b_bus.pin        = ext_irq_pin_b;
  assign pin_b_bus.pin_enable = cfg_pin_b_enable;
  assign pin_b_bus.rising     = cfg_pin_b_rising;

  mviu_edge_detect u_edge_a (
    .clock    (clock),
    .rst_n    (rst_n),
    .clk_en   (clk_en),
    .edge_bus (pin_a_bus.detector)
  );

  mviu_edge_detect u_edge_b (
    .clock    (clock),
    .rst_n    (rst_n),
    .clk_en   (clk_en),
    .edge_bus (pin_b_bus.detector)
  );

  // Hardware set events, one per source; both converter timers share one flag.
  assign source_set[`MVIU_SRC_EXT0]  = pin_a_bus.hit;                                  // [RQ5]
  assign source_set[`MVIU_SRC_EXT1]  = pin_b_bus.hit;                                  // [RQ5]
  assign source_set[`MVIU_SRC_TIMER] = timer_overflow;                                 // [RQ7]
  assign source_set[`MVIU_SRC_CONV]  = conv_timer_a_overflow | conv_timer_b_overflow;  // [RQ8]

  // Register decode at the two documented data addresses.
  assign wr_primary   = reg_wr && (reg_addr == `MVIU_ADDR_PRIMARY);    // [RQ1]
  assign wr_secondary = reg_wr && (reg_addr == `MVIU_ADDR_SECONDARY);  // [RQ1]

  // A source is eligible only with flag, own enable and global enable all set,
  // and is acknowledged only while the return stack still has room.
  assign eligible = st_r.request & st_r.enable & {4{st_r.global_irq_enable}};  // [RQ18] [RQ11]
  assign take_ack = phase_two_pulse && !stack_full && (|eligible);            // [RQ10] [RQ3]

  // Fixed priority: the lowest index wins, so pin 0 beats everything.
  always_comb begin
    winner     = 4'h0;
    win_vector = `MVIU_RST_BYTE;
    if (eligible[`MVIU_SRC_EXT0]) begin
      winner[`MVIU_SRC_EXT0] = 1'b1;   // [RQ11]
      win_vector             = `MVIU_VEC_EXT0;  // [RQ6]
    end else if (eligible[`MVIU_SRC_EXT1]) begin
      winner[`MVIU_SRC_EXT1] = 1'b1;
      win_vector             = `MVIU_VEC_EXT1;  // [RQ6]
    end else if (eligible[`MVIU_SRC_TIMER]) begin
      winner[`MVIU_SRC_TIMER] = 1'b1;
      win_vector              = `MVIU_VEC_TIMER;  // [RQ7]
    end else if (eligible[`MVIU_SRC_CONV]) begin
      winner[`MVIU_SRC_CONV] = 1'b1;
      win_vector             = `MVIU_VEC_CONV;  // [RQ8]
    end
  end

  // Next-state logic of the whole unit.
  always_comb begin
    st_nxt     = st_r;
    st_nxt.ack = 1'b0;

    // Software writes load the enables; the global enable also follows the handler's
    // return. An acknowledge in the same cycle as a write is overridden by the write,
    // which is the later effect in the instruction.
    if (wr_primary) begin
      st_nxt.global_irq_enable         = reg_wdata[`MVIU_P_GLOBAL_EN];
      st_nxt.enable[`MVIU_SRC_EXT0]    = reg_wdata[`MVIU_P_EXT0_EN];
      st_nxt.enable[`MVIU_SRC_EXT1]    = reg_wdata[`MVIU_P_EXT1_EN];
      st_nxt.enable[`MVIU_SRC_TIMER]   = reg_wdata[`MVIU_P_TIMER_EN];
    end else if (take_ack) begin
      st_nxt.global_irq_enable = 1'b0;  // [RQ2]
    end else if (return_from_irq_op) begin
      st_nxt.global_irq_enable = 1'b1;  // [RQ9]
    end
    // A plain return needs no branch here: the global enable simply holds. [RQ9]
    if (wr_secondary) begin
      st_nxt.enable[`MVIU_SRC_CONV] = reg_wdata[`MVIU_S_CONV_EN];
    end

    // Flags: software write or acknowledge may clear, but a hardware set always wins.
    if (wr_primary) begin
      st_nxt.request[`MVIU_SRC_EXT0]  = reg_wdata[`MVIU_P_EXT0_REQ];
      st_nxt.request[`MVIU_SRC_EXT1]  = reg_wdata[`MVIU_P_EXT1_REQ];
      st_nxt.request[`MVIU_SRC_TIMER] = reg_wdata[`MVIU_P_TIMER_REQ];
    end
    if (wr_secondary) begin
      st_nxt.request[`MVIU_SRC_CONV] = reg_wdata[`MVIU_S_CONV_REQ];
    end
    if (take_ack) begin
      st_nxt.request = st_nxt.request & ~winner;  // [RQ6] [RQ7] [RQ8]
    end
    st_nxt.request = st_nxt.request | source_set;  // [RQ14] [RQ2]

    // Acknowledge: the core pushes only the program counter and branches to the vector.
    if (take_ack) begin
      st_nxt.ack    = 1'b1;        // [RQ4]
      st_nxt.vector = win_vector;  // [RQ4]
    end

    // Flags already pending at power-down entry lose their wake-up capability.
    st_nxt.power_down_seen = power_down;
    if (power_down && !st_r.power_down_seen) begin
      st_nxt.wake_block = st_r.request;  // [RQ17]
    end else if (!power_down) begin
      st_nxt.wake_block = `MVIU_RST_REQUESTS;
    end
    st_nxt.wake = power_down && st_r.power_down_seen &&
                  (|(st_r.request & ~st_r.wake_block));  // [RQ16] [RQ17]

    // Read data for the addressed register; unused bits read as zero.
    unique case (reg_addr)
      `MVIU_ADDR_PRIMARY: begin
        st_nxt.rd_data                       = `MVIU_RST_BYTE;  // [RQ12]
        st_nxt.rd_data[`MVIU_P_GLOBAL_EN]    = st_r.global_irq_enable;
        st_nxt.rd_data[`MVIU_P_EXT0_EN]      = st_r.enable[`MVIU_SRC_EXT0];
        st_nxt.rd_data[`MVIU_P_EXT1_EN]      = st_r.enable[`MVIU_SRC_EXT1];
        st_nxt.rd_data[`MVIU_P_TIMER_EN]     = st_r.enable[`MVIU_SRC_TIMER];
        st_nxt.rd_data[`MVIU_P_EXT0_REQ]     = st_r.request[`MVIU_SRC_EXT0];
        st_nxt.rd_data[`MVIU_P_EXT1_REQ]     = st_r.request[`MVIU_SRC_EXT1];
        st_nxt.rd_data[`MVIU_P_TIMER_REQ]    = st_r.request[`MVIU_SRC_TIMER];
      end
      `MVIU_ADDR_SECONDARY: begin
        st_nxt.rd_data                       = `MVIU_RST_BYTE;  // [RQ13]
        st_nxt.rd_data[`MVIU_S_CONV_EN]      = st_r.enable[`MVIU_SRC_CONV];
        st_nxt.rd_data[`MVIU_S_CONV_REQ]     = st_r.request[`MVIU_SRC_CONV];
      end
      default: begin
        st_nxt.rd_data = `MVIU_RST_BYTE;
      end
    endcase
  end

  // State register, frozen while the clock enable is low.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_r                   <= '0;
      st_r.enable            <= `MVIU_RST_ENABLES;
      st_r.request           <= `MVIU_RST_REQUESTS;
      st_r.global_irq_enable <= 1'b0;
    end else if (clk_en) begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from the state register.
  assign reg_rd_data = st_r.rd_data;
  assign irq_ack     = st_r.ack;
  assign irq_vector  = st_r.vector;
  assign wake_up     = st_r.wake;

  // Every check runs on the system clock and is idle during reset. Antecedents carry the
  // clock enable, because a frozen cycle changes no state and an output may then stand longer.
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  AST_ACK_AT_PHASE_TWO: assert property ( // [RQ10]
    (clk_en && phase_two_pulse && !stack_full && (|eligible)) |=> irq_ack)
    else $error("Eligible request at phase-two pulse was not acknowledged.");

  AST_STACK_FULL_BLOCKS: assert property ( // [RQ3]
    (clk_en && stack_full) |=> !irq_ack)
    else $error("Acknowledge given while the stack was full.");

  AST_ACK_NEEDS_PHASE_TWO: assert property ( // [RQ18]
    (irq_ack && $past(clk_en)) |-> $past(phase_two_pulse) && $past(st_r.global_irq_enable))
    else $error("Acknowledge without phase-two pulse or global enable.");

  AST_ACK_CLEARS_GLOBAL: assert property ( // [RQ2]
    (clk_en && take_ack && !wr_primary) |=> !st_r.global_irq_enable)
    else $error("Global enable still set after acknowledge.");

  AST_PIN0_FIRST: assert property ( // [RQ11]
    (clk_en && take_ack && eligible[`MVIU_SRC_EXT0]) |=> irq_vector == `MVIU_VEC_EXT0)
    else $error("Pin 0 request lost priority.");

  AST_TIMER_VECTOR: assert property ( // [RQ7]
    (clk_en && take_ack && eligible[2:0] == 3'b100 && !source_set[2])
    |=> irq_vector == `MVIU_VEC_TIMER && !st_r.request[2])
    else $error("Timer acknowledge wrong vector or flag kept.");

  AST_CONV_VECTOR: assert property ( // [RQ8]
    (clk_en && take_ack && eligible == 4'b1000 && !source_set[3])
    |=> irq_vector == `MVIU_VEC_CONV && !st_r.request[3])
    else $error("Converter acknowledge wrong vector or flag kept.");

  AST_RETURN_FROM_IRQ_OP_SETS_GLOBAL: assert property ( // [RQ9]
    (clk_en && return_from_irq_op && !take_ack && !wr_primary) |=> st_r.global_irq_enable)
    else $error("Return from interrupt did not set the global enable.");

  AST_FLAG_SET_WINS: assert property ( // [RQ14]
    (clk_en && source_set[`MVIU_SRC_EXT0]) |=> st_r.request[`MVIU_SRC_EXT0] ##1 1'b1)
    else $error("Pin 0 request flag not set by its event.");

  AST_SECONDARY_ZEROS: assert property ( // [RQ13]
    (clk_en && reg_addr == `MVIU_ADDR_SECONDARY) |=> reg_rd_data[3:1] == 3'h0 && reg_rd_data[7:5] == 3'h0)
    else $error("Unused secondary bits read non-zero.");

  AST_WAKE_ONLY_IN_POWER_DOWN: assert property ( // [RQ16]
    (wake_up && $past(clk_en)) |-> $past(power_down) && $past(st_r.power_down_seen))
    else $error("Wake-up raised outside power-down.");

  AST_PIN1_VECTOR: assert property ( // [RQ6]
    (clk_en && take_ack && eligible[1:0] == 2'b10 && !source_set[1])
    |=> irq_vector == `MVIU_VEC_EXT1 && !st_r.request[1])
    else $error("Pin 1 acknowledge wrong vector or flag kept.");

  AST_ACK_ONE_CYCLE: assert property ( // [RQ4]
    (clk_en && irq_ack && !phase_two_pulse) |=> !irq_ack)
    else $error("Acknowledge pulse stood for more than one cycle.");

  AST_MASKED_BY_GLOBAL: assert property ( // [RQ11]
    (clk_en && !st_r.global_irq_enable) |=> !irq_ack)
    else $error("Acknowledge given while the global enable was clear.");

  AST_NO_REQUEST_NO_ACK: assert property ( // [RQ18]
    (clk_en && (st_r.request & st_r.enable) == 4'h0) |=> !irq_ack)
    else $error("Acknowledge given without an enabled pending flag.");

  AST_PRIMARY_BIT7_ZERO: assert property ( // [RQ12]
    (clk_en && reg_addr == `MVIU_ADDR_PRIMARY) |=> reg_rd_data[7] == 1'b0)
    else $error("Unused primary bit 7 read non-zero.");

  AST_PLAIN_RETURN_KEEPS: assert property ( // [RQ9]
    (clk_en && plain_return_op && !return_from_irq_op && !take_ack && !wr_primary)
    |=> st_r.global_irq_enable == $past(st_r.global_irq_enable))
    else $error("Plain return changed the global enable.");

  AST_CONV_EITHER_TIMER: assert property ( // [RQ8]
    (clk_en && (conv_timer_a_overflow || conv_timer_b_overflow)) |=> st_r.request[`MVIU_SRC_CONV])
    else $error("Converter flag not set by a converter timer overflow.");

  // Main scenarios the bench is expected to reach.
  COV_ACK_PIN0: cover property (clk_en && take_ack && winner[`MVIU_SRC_EXT0]);
  COV_ACK_TIMER: cover property (clk_en && take_ack && winner[`MVIU_SRC_TIMER]);
  COV_ACK_CONV: cover property (clk_en && take_ack && winner[`MVIU_SRC_CONV]);
  COV_STACK_FULL_HOLD: cover property (clk_en && phase_two_pulse && stack_full && (|eligible));
  COV_WAKE: cover property (wake_up);

endmodule : mviu_unit

// File: bench/mviu_core_model.sv
// Behavioural core sequencer: phase-two pulses, a small return stack and return instructions.
`timescale 1ns/1ps
module mviu_core_model #(
  parameter int P2_PERIOD   = 4,
  parameter int STACK_DEPTH = 2
) (
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst_n,
  // Acknowledge from the unit and return requests from the bench
  input  wire logic irq_ack,
  input  wire logic ret_irq_req,
  input  wire logic ret_plain_req,
  // Sequencer outputs
  output logic      phase_two_pulse,
  output logic      stack_full,
  output logic      return_from_irq_op,
  output logic      plain_return_op
);
  int phase_cnt;
  int depth;

  // A shallow stack makes the full condition easy to reach; the bench never returns in an ack cycle.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      phase_cnt          <= 0;
      depth              <= 0;
      phase_two_pulse    <= 1'b0;
      return_from_irq_op <= 1'b0;
      plain_return_op    <= 1'b0;
    end else begin
      phase_cnt          <= (phase_cnt == P2_PERIOD - 1) ? 0 : phase_cnt + 1;
      phase_two_pulse    <= (phase_cnt == P2_PERIOD - 1);
      return_from_irq_op <= ret_irq_req;
      plain_return_op    <= ret_plain_req;
      if (irq_ack && depth < STACK_DEPTH) begin
        depth <= depth + 1; // Only the return address is pushed.
      end else if ((ret_irq_req || ret_plain_req) && depth > 0) begin
        depth <= depth - 1;
      end
    end
  end

  // Full as soon as every level holds a return address.
  assign stack_full = (depth == STACK_DEPTH);
endmodule : mviu_core_model

// File: bench/mcu_vectored_interrupt_unit_tb.sv
// Self-checking testbench of the vectored interrupt unit with a behavioural core.
`timescale 1ns/1ps
`include "mviu_defines.svh"
module mcu_vectored_interrupt_unit_tb;
  logic       clock = 1'b0;
  logic       rst_n = 1'b0;
  logic       clk_en = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic       reg_wr = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rd_data;
  logic       pin_a = 1'b1;
  logic       pin_b = 1'b0;
  logic       timer_ovf = 1'b0;
  logic       conv_a = 1'b0;
  logic       conv_b = 1'b0;
  logic       power_down = 1'b0;
  logic       ret_irq_req = 1'b0;
  logic       ret_plain_req = 1'b0;
  logic       p2, full, ret_irq, ret_plain, irq_ack, wake_up;
  logic [7:0] irq_vector;
  int         errors = 0;
  int         tests_run = 0;
  int         cycles = 0;

  mviu_unit dut (.clock(clock), .rst_n(rst_n), .clk_en(clk_en), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd_data(reg_rd_data), .ext_irq_pin_a(pin_a), .ext_irq_pin_b(pin_b),
    .timer_overflow(timer_ovf), .conv_timer_a_overflow(conv_a), .conv_timer_b_overflow(conv_b),
    .cfg_pin_a_enable(1'b1), .cfg_pin_a_rising(1'b0), .cfg_pin_b_enable(1'b1), .cfg_pin_b_rising(1'b1),
    .phase_two_pulse(p2), .stack_full(full), .return_from_irq_op(ret_irq), .plain_return_op(ret_plain),
    .power_down(power_down), .irq_ack(irq_ack), .irq_vector(irq_vector), .wake_up(wake_up));

  mviu_core_model core (.clock(clock), .rst_n(rst_n), .irq_ack(irq_ack), .ret_irq_req(ret_irq_req),
    .ret_plain_req(ret_plain_req), .phase_two_pulse(p2), .stack_full(full),
    .return_from_irq_op(ret_irq), .plain_return_op(ret_plain));

  // The clock runs at 100 MHz.
  initial begin
    forever #5 clock = ~clock;
  end

  // A hang is cut short well above the six hundred or so cycles the tests need.
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      $display("Error at %0t: timeout", $time);
      close_out();
    end
  end

  function automatic logic [7:0] lfsr_next(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : lfsr_next

  // Vector table in priority order.
  function automatic logic [7:0] vec_of(input int i);
    case (i)
      0: return `MVIU_VEC_EXT0;
      1: return `MVIU_VEC_EXT1;
      2: return `MVIU_VEC_TIMER;
      default: return `MVIU_VEC_CONV;
    endcase
  endfunction : vec_of

  task automatic check(input logic ok, input string msg);
    tests_run++;
    if (ok !== 1'b1) begin
      errors++;
      $display("Error at %0t: %s", $time, msg);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clock);
    reg_wr    <= 1'b0;
  endtask : wr

  // Read data is registered at the edge that samples the address.
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock);
    reg_addr <= a;
    @(posedge clock);
    #1;
    check(reg_rd_data === e, "read data mismatch");
  endtask : rd

  task automatic ret_pulse(input bit irq);
    @(posedge clock);
    if (irq) ret_irq_req <= 1'b1;
    else ret_plain_req <= 1'b1;
    @(posedge clock);
    ret_irq_req   <= 1'b0;
    ret_plain_req <= 1'b0;
  endtask : ret_pulse

  // Bounded by one phase-two period plus the flag and ack latency.
  task automatic wait_ack(input logic [7:0] v);
    bit seen;
    seen = 0;
    for (int k = 0; k < 8 && !seen; k++) begin
      @(posedge clock);
      #1;
      seen = (irq_ack === 1'b1);
    end
    check(seen && irq_vector === v, "ack or vector mismatch");
    @(posedge clock);
    #1;
    check(irq_ack === 1'b0, "ack longer than one cycle");
  endtask : wait_ack

  task automatic no_ack(input int n);
    bit seen;
    seen = 0;
    repeat (n) begin
      @(posedge clock);
      #1;
      if (irq_ack === 1'b1) seen = 1;
    end
    check(!seen, "unexpected ack");
  endtask : no_ack

  // Pin a fires on a falling edge and pin b on a rising edge, as configured at the ports.
  task automatic fire(input int i, input logic alt);
    @(posedge clock);
    case (i)
      0: pin_a <= 1'b0;
      1: pin_b <= 1'b1;
      2: timer_ovf <= 1'b1;
      default: if (alt) conv_a <= 1'b1; else conv_b <= 1'b1;
    endcase
    // All sources return to idle after one cycle, so an acknowledge at the next edge is seen.
    @(posedge clock);
    {timer_ovf, conv_a, conv_b} <= 3'b000;
    pin_a <= 1'b1;
    pin_b <= 1'b0;
  endtask : fire

  task automatic close_out();
    $display("Counts: %0d checks, %0d mismatches", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : close_out

  // Main sequence: register map, random priority rounds, full stack, power-down wake.
  initial begin
    logic [7:0] lf;
    logic [3:0] mask;
    lf = 8'h30;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    repeat (3) @(posedge clock);
    rd(8'h0B, 8'h00);
    rd(8'h1E, 8'h00);
    wr(8'h0B, 8'hF0);
    rd(8'h0B, 8'h70);
    wr(8'h1E, 8'hFE);
    rd(8'h1E, 8'h10);
    wr(8'h0C, 8'hFF);
    rd(8'h0C, 8'h00);
    wr(8'h0B, 8'h00);
    wr(8'h1E, 8'h00);
    clk_en <= 1'b0;
    wr(8'h0B, 8'h0F);
    clk_en <= 1'b1;
    rd(8'h0B, 8'h00);
    $display("Test registers finished");
    for (int r = 0; r < 8; r++) begin
      lf   = lfsr_next(lf);
      mask = (r == 0) ? 4'hF : lf[3:0];
      wr(8'h0B, 8'h0E);
      wr(8'h1E, 8'h01);
      for (int i = 0; i < 4; i++) if (mask[i]) fire(i, lf[4]);
      no_ack(10);
      rd(8'h0B, {1'b0, mask[2:0], 4'hE});
      rd(8'h1E, {3'b000, mask[3], 4'h1});
      wr(8'h0B, {1'b0, mask[2:0], 4'hF});
      for (int i = 0; i < 4; i++) begin
        if (mask[i]) begin
          wait_ack(vec_of(i));
          no_ack(6);
          ret_pulse(1'b1);
        end
      end
      no_ack(10);
      wr(8'h0B, 8'h00);
    end
    $display("Test priority finished");
    wr(8'h0B, 8'h09);
    fire(2, 1'b0);
    wait_ack(`MVIU_VEC_TIMER);
    wr(8'h0B, 8'h09);
    fire(2, 1'b0);
    wait_ack(`MVIU_VEC_TIMER);
    wr(8'h0B, 8'h09);
    fire(2, 1'b0);
    no_ack(12);
    rd(8'h0B, 8'h49);
    ret_pulse(1'b0);
    wait_ack(`MVIU_VEC_TIMER);
    ret_pulse(1'b0);
    rd(8'h0B, 8'h08);
    ret_pulse(1'b1);
    rd(8'h0B, 8'h09);
    $display("Test stack finished");
    wr(8'h0B, 8'h08);
    fire(2, 1'b0);
    @(posedge clock);
    power_down <= 1'b1;
    repeat (5) @(posedge clock);
    #1;
    check(wake_up === 1'b0, "wake from a flag set before power-down");
    fire(0, 1'b0);
    repeat (2) @(posedge clock);
    #1;
    check(wake_up === 1'b1, "no wake from new request");
    @(posedge clock);
    power_down <= 1'b0;
    $display("Test power-down finished");
    close_out();
  end
endmodule : mcu_vectored_interrupt_unit_tb
